// file: verilog/wdt_defs.vh
// Constants shared by the watchdog down counter and its prescaler
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// Register reset values
`define WDT_CTRL_RESET 16'h00E9
`define WDT_LOAD_RESET 16'h0400
`define WDT_COUNT_RESET 16'h1000
`define WDT_STATUS_RESET 16'h0020

// Counter constants
`define WDT_FIXED_START 16'h1000
`define WDT_COUNT_ONE 16'h0001
`define WDT_COUNT_ZERO 16'h0000
`define WDT_SERVICE_WORD 16'hCCCC

// Control field positions and writable mask
`define WDT_BIT_FREEZE 0
`define WDT_BIT_IRQ_SEL 1
`define WDT_PRE_LO 2
`define WDT_PRE_HI 3
`define WDT_BIT_ENABLE 5
`define WDT_BIT_MODE 6
`define WDT_CTRL_MASK 16'h006F

// Prescaler select codes and last count of each division
`define WDT_PRE_DIV1 2'h0
`define WDT_PRE_DIV16 2'h1
`define WDT_PRE_DIV256 2'h2
`define WDT_PRE_DIV4096 2'h3
`define WDT_PRE_LAST1 12'h000
`define WDT_PRE_LAST16 12'h00F
`define WDT_PRE_LAST256 12'h0FF
`define WDT_PRE_LAST4096 12'hFFF
`define WDT_PRE_ZERO 12'h000
`define WDT_PRE_ONE 12'h001

// Status bit positions
`define WDT_ST_IRQ 0
`define WDT_ST_CLR_SYNC 1
`define WDT_ST_LOAD_SYNC 2
`define WDT_ST_CTRL_SYNC 3
`define WDT_ST_FROZEN 4
`define WDT_ST_ENABLED 5
`define WDT_ST_LOCKED 6

`endif

// file: verilog/wdt_prescaler.v
// Prescaler that turns oscillator ticks into counter decrements
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module wdt_prescaler (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_lf_tick,
  input wire i_run,
  input wire i_restart,
  input wire [1:0] i_sel,
  output reg o_dec
);

  reg [11:0] div_q;
  reg [11:0] last;

  always @* begin
    case (i_sel)
      `WDT_PRE_DIV1: last = `WDT_PRE_LAST1;
      `WDT_PRE_DIV16: last = `WDT_PRE_LAST16;
      `WDT_PRE_DIV256: last = `WDT_PRE_LAST256;
      `WDT_PRE_DIV4096: last = `WDT_PRE_LAST4096;
      default: last = `WDT_PRE_LAST256;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q <= `WDT_PRE_ZERO;
      o_dec <= 1'b0;
    end else if (i_restart) begin
      div_q <= `WDT_PRE_ZERO;
      o_dec <= 1'b0;
    end else if (i_lf_tick && i_run) begin
      if (div_q >= last) begin
        div_q <= `WDT_PRE_ZERO;
        o_dec <= 1'b1;
      end else begin
        div_q <= div_q + `WDT_PRE_ONE;
        o_dec <= 1'b0;
      end
    end else begin
      o_dec <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/watchdog_down_counter.v
// Prescaled 16-bit watchdog down counter with service word and lock
//
// How it works
// - Sixteen-bit down counter, prescaled by 1, 16, 256 or 4096.
// - Counter paced by oscillator ticks, running only while enabled and not frozen.
// - Counting never depends on boot or download mode.
// - Expiry gives reset pulse, or interrupt when interrupt-select bit 1 set.
// - Writing service word CCCC clears a pending interrupt.
// - After reset load is 0400 and the watchdog is enabled.
// - Periodic timeout period is prescale times load plus one ticks.
// - Setting enable locks control and load until power cycle.
// - Before locking, control and load may change freely; disable stops.
// - Fixed mode counts 1000 down to zero and wraps to 1000.
// - Periodic mode uses load value and prescaler field bits 3:2.
// - Reaching zero raises the selected timeout action.
// - Correct service reloads counter and starts a new period.
// - Wrong service word raises the timeout action at once.
// - Freeze bit holds the count while the core is halted.
// - First control write with enable clear resets and disables.
// - Later write setting enable restarts from 1000 or load.
// - Load write in periodic mode moves value into the counter.
// - Prescale codes 00, 01, 10, 11 give divide 1, 16, 256, 4096.
// - Writes cross into tick timing; busy bits show pending writes.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module watchdog_down_counter (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_lf_tick,
  input wire i_core_halted,
  input wire i_ctrl_wr,
  input wire [15:0] i_ctrl_wdata,
  input wire i_load_wr,
  input wire [15:0] i_load_wdata,
  input wire i_clear_wr,
  input wire [15:0] i_clear_wdata,
  output reg [15:0] o_wdt_control,
  output reg [15:0] o_wdt_load_value,
  output reg [15:0] o_wdt_current_count,
  output reg [15:0] o_wdt_status,
  output reg o_wdt_reset_req,
  output reg o_wdt_irq
);

  // Lock states
  localparam [1:0] ST_INIT = 2'b00;
  localparam [1:0] ST_OPEN = 2'b01;
  localparam [1:0] ST_LOCKED = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;

  reg [15:0] ctrl_d;
  reg [15:0] load_d;
  reg [15:0] count_d;
  reg [15:0] status_d;
  reg reset_req_d;
  reg irq_d;

  // Writes waiting for the next oscillator tick
  reg ctrl_pend_q;
  reg load_pend_q;
  reg clr_pend_q;
  reg [15:0] ctrl_buf_q;
  reg [15:0] load_buf_q;
  reg [15:0] clr_buf_q;

  wire apply_tick;
  wire apply_ctrl;
  wire apply_load;
  wire apply_clr;
  wire good_service;
  wire enabled;
  wire periodic;
  wire irq_sel;
  wire frozen;
  wire run;
  wire dec;
  wire restart_pre;
  wire new_enable;
  wire new_periodic;
  wire [15:0] reload_value;
  wire [15:0] new_ctrl;

  reg fire;

  assign enabled = o_wdt_control[`WDT_BIT_ENABLE];
  assign periodic = o_wdt_control[`WDT_BIT_MODE];
  assign irq_sel = o_wdt_control[`WDT_BIT_IRQ_SEL];

  assign apply_tick = i_lf_tick;
  assign apply_ctrl = apply_tick && ctrl_pend_q && (state_q != ST_LOCKED);
  assign apply_load = apply_tick && load_pend_q && (state_q != ST_LOCKED);
  assign apply_clr = apply_tick && clr_pend_q;
  assign good_service = (clr_buf_q == `WDT_SERVICE_WORD);

  assign new_ctrl = ctrl_buf_q & `WDT_CTRL_MASK;
  assign new_enable = new_ctrl[`WDT_BIT_ENABLE];
  assign new_periodic = new_ctrl[`WDT_BIT_MODE];

  assign reload_value = periodic ? o_wdt_load_value : `WDT_FIXED_START;

  assign frozen = o_wdt_control[`WDT_BIT_FREEZE] && i_core_halted;
  assign run = enabled && !frozen;
  // Restarting the divider keeps a fresh period exactly prescale long
  assign restart_pre = apply_ctrl || apply_load || apply_clr;

  wdt_prescaler u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_lf_tick(i_lf_tick),
    .i_run(run),
    .i_restart(restart_pre),
    .i_sel(o_wdt_control[`WDT_PRE_HI:`WDT_PRE_LO]),
    .o_dec(dec)
  );

  // Pending write capture; a new write beats the apply clear
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_pend_q <= 1'b0;
      load_pend_q <= 1'b0;
      clr_pend_q <= 1'b0;
      ctrl_buf_q <= `WDT_CTRL_RESET;
      load_buf_q <= `WDT_LOAD_RESET;
      clr_buf_q <= `WDT_SERVICE_WORD;
    end else begin
      if (i_ctrl_wr) begin
        ctrl_pend_q <= 1'b1;
        ctrl_buf_q <= i_ctrl_wdata;
      end else if (apply_tick) begin
        ctrl_pend_q <= 1'b0;
      end
      if (i_load_wr) begin
        load_pend_q <= 1'b1;
        load_buf_q <= i_load_wdata;
      end else if (apply_tick) begin
        load_pend_q <= 1'b0;
      end
      if (i_clear_wr) begin
        clr_pend_q <= 1'b1;
        clr_buf_q <= i_clear_wdata;
      end else if (apply_tick) begin
        clr_pend_q <= 1'b0;
      end
    end
  end

  // Lock sequence, control and load update
  always @* begin
    state_d = state_q;
    ctrl_d = o_wdt_control;
    load_d = o_wdt_load_value;
    if (apply_ctrl) begin
      ctrl_d = new_ctrl;
      case (state_q)
        ST_INIT: begin
          state_d = new_enable ? ST_LOCKED : ST_OPEN;
        end
        ST_OPEN: begin
          state_d = new_enable ? ST_LOCKED : ST_OPEN;
        end
        ST_LOCKED: begin
          state_d = ST_LOCKED;
        end
        default: begin
          state_d = ST_LOCKED;
        end
      endcase
    end
    if (apply_load) begin
      load_d = load_buf_q;
    end
  end

  // Counter and timeout action
  always @* begin
    count_d = o_wdt_current_count;
    fire = 1'b0;
    if (apply_ctrl) begin
      if (new_enable) begin
        if (new_periodic) begin
          count_d = apply_load ? load_buf_q : o_wdt_load_value;
        end else begin
          count_d = `WDT_FIXED_START;
        end
      end else begin
        count_d = `WDT_COUNT_RESET;
      end
    end else if (apply_load && periodic) begin
      count_d = load_buf_q;
    end else if (apply_clr) begin
      if (good_service) begin
        count_d = reload_value;
      end else begin
        fire = 1'b1;
      end
    end else if (dec) begin
      if (o_wdt_current_count == `WDT_COUNT_ZERO) begin
        count_d = reload_value;
      end else begin
        count_d = o_wdt_current_count - `WDT_COUNT_ONE;
        if (o_wdt_current_count == `WDT_COUNT_ONE) begin
          fire = 1'b1;
        end
      end
    end
  end

  // Action routing; a new timeout beats a service clear
  always @* begin
    reset_req_d = 1'b0;
    irq_d = o_wdt_irq;
    if (apply_clr && good_service) begin
      irq_d = 1'b0;
    end
    if (fire) begin
      if (irq_sel) begin
        irq_d = 1'b1;
      end else begin
        reset_req_d = 1'b1;
      end
    end
  end

  // Status word
  always @* begin
    status_d = `WDT_COUNT_ZERO;
    status_d[`WDT_ST_IRQ] = irq_d;
    status_d[`WDT_ST_CLR_SYNC] = i_clear_wr || (clr_pend_q && !apply_tick);
    status_d[`WDT_ST_LOAD_SYNC] = i_load_wr ||
      (load_pend_q && !apply_tick);
    status_d[`WDT_ST_CTRL_SYNC] = i_ctrl_wr ||
      (ctrl_pend_q && !apply_tick);
    status_d[`WDT_ST_FROZEN] = ctrl_d[`WDT_BIT_FREEZE] && i_core_halted;
    status_d[`WDT_ST_ENABLED] = ctrl_d[`WDT_BIT_ENABLE];
    status_d[`WDT_ST_LOCKED] = (state_d == ST_LOCKED);
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_INIT;
      o_wdt_control <= `WDT_CTRL_RESET;
      o_wdt_load_value <= `WDT_LOAD_RESET;
      o_wdt_current_count <= `WDT_COUNT_RESET;
      o_wdt_status <= `WDT_STATUS_RESET;
      o_wdt_reset_req <= 1'b0;
      o_wdt_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      o_wdt_control <= ctrl_d;
      o_wdt_load_value <= load_d;
      o_wdt_current_count <= count_d;
      o_wdt_status <= status_d;
      o_wdt_reset_req <= reset_req_d;
      o_wdt_irq <= irq_d;
    end
  end

endmodule
`default_nettype wire

// file: verification/watchdog_down_counter_props.sv
// Port assertions for the watchdog down counter
`timescale 1ns/1ps
`default_nettype none
module watchdog_down_counter_props (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_lf_tick,
  input wire logic i_core_halted,
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_wdata,
  input wire logic i_load_wr,
  input wire logic [15:0] i_load_wdata,
  input wire logic i_clear_wr,
  input wire logic [15:0] i_clear_wdata,
  input wire logic [15:0] o_wdt_control,
  input wire logic [15:0] o_wdt_load_value,
  input wire logic [15:0] o_wdt_current_count,
  input wire logic [15:0] o_wdt_status,
  input wire logic o_wdt_reset_req,
  input wire logic o_wdt_irq
);
  logic [15:0] clr_word_q;
  wire quiet = !i_ctrl_wr && !i_load_wr && !i_clear_wr &&
    o_wdt_status[3:1] == 3'h0;
  // Divide by one only, so every tick must move the count
  wire run = o_wdt_status[5] && o_wdt_control[3:2] == 2'h0 &&
    !(i_core_halted && o_wdt_control[0]);
  wire clr_apply = i_lf_tick && o_wdt_status[1] && !i_clear_wr &&
    !i_ctrl_wr && !i_load_wr && o_wdt_status[3:2] == 2'h0;
  always_ff @(posedge i_sys_clk) begin
    if (i_clear_wr) begin
      clr_word_q <= i_clear_wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Applies land one edge after a tick, decrements one edge later still
  a_count_holds: assert property (!$past(i_lf_tick) &&
    !$past(i_lf_tick, 2) |-> $stable(o_wdt_current_count))
    else $error("count moved without tick");
  a_tick_dec: assert property (i_lf_tick && run && quiet &&
    o_wdt_current_count > 16'h0001 |-> ##2 o_wdt_current_count ==
    $past(o_wdt_current_count, 2) - 16'h0001) else $error("no decrement");
  a_expiry_fires: assert property (i_lf_tick && run && quiet &&
    o_wdt_current_count == 16'h0001 |-> ##2 o_wdt_reset_req || o_wdt_irq)
    else $error("expiry without action");
  a_bad_word: assert property (clr_apply && clr_word_q != 16'hCCCC
    |=> o_wdt_reset_req || o_wdt_irq) else $error("bad word ignored");
  a_good_clear: assert property (clr_apply && clr_word_q == 16'hCCCC &&
    o_wdt_current_count > 16'h0001 |=> !o_wdt_irq && o_wdt_current_count ==
    ($past(o_wdt_control[6]) ? $past(o_wdt_load_value) : 16'h1000))
    else $error("service did not reload");
  a_irq_sticky: assert property (o_wdt_irq && !i_clear_wr &&
    !o_wdt_status[1] |=> o_wdt_irq) else $error("irq dropped");
  a_pulse_one: assert property (o_wdt_reset_req |=> !o_wdt_reset_req)
    else $error("reset request too long");
  a_action_sel: assert property ((o_wdt_reset_req || $rose(o_wdt_irq))
    |-> o_wdt_irq == $past(o_wdt_control[1])) else $error("wrong action");
  a_lock_holds: assert property (o_wdt_status[6] |=>
    $stable(o_wdt_control) && $stable(o_wdt_load_value))
    else $error("locked register changed");
  a_busy_flag: assert property (i_ctrl_wr && !i_lf_tick |=>
    o_wdt_status[3]) else $error("busy flag missing");
  cover property (o_wdt_reset_req);
  cover property ($rose(o_wdt_irq));
  cover property ($rose(o_wdt_status[6]));
endmodule
bind watchdog_down_counter watchdog_down_counter_props
  i_watchdog_down_counter_props (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_lf_tick(i_lf_tick), .i_core_halted(i_core_halted),
  .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
  .i_load_wr(i_load_wr), .i_load_wdata(i_load_wdata),
  .i_clear_wr(i_clear_wr), .i_clear_wdata(i_clear_wdata),
  .o_wdt_control(o_wdt_control), .o_wdt_load_value(o_wdt_load_value),
  .o_wdt_current_count(o_wdt_current_count), .o_wdt_status(o_wdt_status),
  .o_wdt_reset_req(o_wdt_reset_req), .o_wdt_irq(o_wdt_irq));
`default_nettype wire

// file: verification/tb_watchdog_down_counter.sv
// Self-checking bench for the watchdog down counter
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_down_counter;
  localparam logic [2:0] CTL = 3'h1;
  localparam logic [2:0] LDW = 3'h2;
  localparam logic [2:0] CLR = 3'h4;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_lf_tick = 1'b0;
  logic i_core_halted = 1'b0;
  logic i_ctrl_wr = 1'b0;
  logic i_load_wr = 1'b0;
  logic i_clear_wr = 1'b0;
  logic [15:0] i_ctrl_wdata = 16'h0000;
  logic [15:0] i_load_wdata = 16'h0000;
  logic [15:0] i_clear_wdata = 16'h0000;
  wire [15:0] o_wdt_control, o_wdt_load_value, o_wdt_current_count;
  wire [15:0] o_wdt_status;
  wire o_wdt_reset_req, o_wdt_irq;
  int n_errors = 0;
  int samples_checked = 0;
  logic fired = 1'b0;
  int k;
  always #2.5 i_sys_clk = ~i_sys_clk;
  watchdog_down_counter i_watchdog_down_counter (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_lf_tick(i_lf_tick), .i_core_halted(i_core_halted),
    .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
    .i_load_wr(i_load_wr), .i_load_wdata(i_load_wdata),
    .i_clear_wr(i_clear_wr), .i_clear_wdata(i_clear_wdata),
    .o_wdt_control(o_wdt_control), .o_wdt_load_value(o_wdt_load_value),
    .o_wdt_current_count(o_wdt_current_count), .o_wdt_status(o_wdt_status),
    .o_wdt_reset_req(o_wdt_reset_req), .o_wdt_irq(o_wdt_irq));
  task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // Full power cycle, the only way out of the lock
  task automatic power_up;
    i_reset <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge i_sys_clk);
    {i_clear_wr, i_load_wr, i_ctrl_wr} <= s;
    i_ctrl_wdata <= d;
    i_load_wdata <= d;
    i_clear_wdata <= d;
    @(posedge i_sys_clk);
    {i_clear_wr, i_load_wr, i_ctrl_wr} <= 3'h0;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_sys_clk) i_lf_tick <= 1'b1;
      @(posedge i_sys_clk) i_lf_tick <= 1'b0;
      #1 fired = o_wdt_reset_req | o_wdt_irq;
      // Decrements land one edge after the tick, so look again
      @(posedge i_sys_clk);
      #1 fired = fired | o_wdt_reset_req | o_wdt_irq;
    end
  endtask
  // Bounded so a dead counter cannot hang the run
  task automatic to_fire;
    k = 0;
    fired = 1'b0;
    while (!fired && k < 5000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic t_reset_values;
    power_up();
    chk("control", 16'h00E9, o_wdt_control);
    chk("load", 16'h0400, o_wdt_load_value);
    chk("count", 16'h1000, o_wdt_current_count);
    chk("status", 16'h0020, o_wdt_status);
    wr(LDW, 16'h0005);
    tick(1);
    chk("count", 16'h0005, o_wdt_current_count);
    $display("test reset_values done");
  endtask
  task automatic t_fixed_irq;
    power_up();
    wr(CTL, 16'h0023);
    tick(1);
    chk("count", 16'h1000, o_wdt_current_count);
    tick(3);
    chk("count", 16'h0FFD, o_wdt_current_count);
    @(posedge i_sys_clk) i_core_halted <= 1'b1;
    tick(2);
    chk("count", 16'h0FFD, o_wdt_current_count);
    chk("frozen", 16'h0010, o_wdt_status & 16'h0010);
    @(posedge i_sys_clk) i_core_halted <= 1'b0;
    wr(CLR, 16'hCCCC);
    tick(1);
    chk("count", 16'h1000, o_wdt_current_count);
    to_fire();
    chk("ticks", 16'h1000, 16'(k));
    tick(1);
    chk("count", 16'h1000, o_wdt_current_count);
    wr(CLR, 16'hCCCC);
    tick(1);
    chk("irq", 16'h0000, {15'h0, o_wdt_irq});
    tick(3);
    wr(CLR, 16'h1234);
    tick(1);
    chk("irq", 16'h0001, {15'h0, o_wdt_irq});
    tick(4);
    chk("irq", 16'h0001, {15'h0, o_wdt_irq});
    wr(CTL, 16'h0000);
    tick(1);
    chk("control", 16'h0023, o_wdt_control);
    chk("locked", 16'h0040, o_wdt_status & 16'h0040);
    $display("test fixed_irq done");
  endtask
  task automatic t_periodic_reset;
    power_up();
    wr(CTL, 16'h0000);
    tick(3);
    chk("count", 16'h1000, o_wdt_current_count);
    chk("enabled", 16'h0000, o_wdt_status & 16'h0060);
    wr(LDW, 16'h0003);
    wr(CTL, 16'h0044);
    chk("busy", 16'h0008, o_wdt_status & 16'h0008);
    tick(1);
    chk("control", 16'h0044, o_wdt_control);
    wr(CTL, 16'h0060);
    tick(1);
    chk("count", 16'h0003, o_wdt_current_count);
    to_fire();
    chk("ticks", 16'h0003, 16'(k));
    chk("irq", 16'h0000, {15'h0, o_wdt_irq});
    to_fire();
    chk("ticks", 16'h0004, 16'(k));
    $display("test periodic_reset done");
  endtask
  task automatic t_prescale;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = 1 << (4 * c);
      power_up();
      wr(CTL, 16'h0060 | (16'(c) << 2));
      tick(n);
      chk("count", 16'h0400, o_wdt_current_count);
      tick(1);
      chk("count", 16'h03FF, o_wdt_current_count);
    end
    $display("test prescale done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_reset_values();
    t_fixed_irq();
    t_periodic_reset();
    t_prescale();
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    $display("BAD run expected done seen timeout");
    summarize();
  end
endmodule
`default_nettype wire
